// File: common/isv_pkg.sv
package isv_pkg;
  localparam int unsigned NUM_VECTORS = 32;
  localparam logic [15:0] VEC_TABLE_BASE = 16'hFFC0;
  localparam logic [15:0] VEC_TABLE_TOP = 16'hFFFE;
  localparam logic [7:0] STACK_RESET = 8'hFF;
  localparam logic [15:0] STACK_PAGE = 16'h0000;
  localparam logic [7:0] COND_CODE_RESET = 8'h08;
  localparam int unsigned MASK_BIT = 3;
  localparam int unsigned PIPE_FILL_BYTES = 3;
  localparam int unsigned FRAME_BYTES = 5;
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_SOFT_INT = 5'h01;

  typedef enum logic [6:0] {
    ISV_RUN = 7'b000_0001,
    ISV_PUSH = 7'b000_0010,
    ISV_VEC_HI = 7'b000_0100,
    ISV_VEC_LO = 7'b000_1000,
    ISV_POP = 7'b001_0000,
    ISV_FILL = 7'b010_0000,
    ISV_RST_VEC = 7'b100_0000
  } isv_state_t;
endpackage : isv_pkg

// File: logic/isv_src_flags.sv
`timescale 1ns/1ps
// per-source sticky flags; events are already synchronous to sys_clk
module isv_src_flags #(
  parameter int unsigned N = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // sources
  input wire logic [N-1:0] evt,
  input wire logic [N-1:0] clr,
  input wire logic [N-1:0] enable,
  // status
  output logic [N-1:0] flag_q,
  output logic [N-1:0] request
);
  logic [N-1:0] flag_d;

  // set wins over a simultaneous clear so no event is lost
  always_comb begin
    flag_d = (flag_q & ~clr) | evt;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign request = flag_q & enable;
endmodule : isv_src_flags

// File: logic/isv_core.sv
`timescale 1ns/1ps
// Contract
// - stack pointer names next free byte
// - push pc low, pc high, x, a, flags
// - after stacking pointer sits below saved flags
// - stacked pc is next instruction address
// - index high byte never saved or restored
// - return pops flags first, pc low last
// - return refills three bytes from popped pc
// - every event sets its flag regardless
// - flag requests only when local enable set
// - accept only mask clear, after instruction
// - set mask, then fetch highest pending vector
// - vector high byte low address, low next
// - lower vector number means higher priority
// - 32 slots from ffc0 up to fffe
// - vector zero serves all reset sources
// - multiple pending: highest priority first
// - any reset sets the global mask
module isv_core #(
  parameter int unsigned N = isv_pkg::NUM_VECTORS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // peripheral sources, one bit per vector number
  input wire logic [N-1:0] src_evt,
  input wire logic [N-1:0] src_clr,
  input wire logic [N-1:0] src_enable,
  // reset causes that re-enter through vector 0
  input wire logic rst_cause,
  // cpu sequencer
  input wire logic insn_boundary,
  input wire logic software_interrupt,
  input wire logic return_from_interrupt,
  input wire logic [15:0] next_pc,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] idx_low_in,
  input wire logic [7:0] condition_code_in,
  input wire logic condition_code_load,
  input wire logic [7:0] stack_pointer_in,
  input wire logic stack_pointer_load,
  // memory port
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr_q,
  output logic [7:0] mem_wdata_q,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // restored state to the sequencer
  output logic busy,
  output logic resume,
  output logic [15:0] prog_counter_q,
  output logic [7:0] acc_q,
  output logic [7:0] idx_low_q,
  output logic [7:0] condition_code_reg_q,
  output logic [7:0] stack_pointer_q,
  output logic [7:0] fill_byte_q,
  output logic fill_valid_q,
  output logic [N-1:0] src_flag
);
  isv_pkg::isv_state_t state_q;
  logic [N-1:0] request;
  logic [2:0] cnt_q;
  logic [4:0] vec_q;
  logic [7:0] frame_q [isv_pkg::FRAME_BYTES];
  logic mask;
  logic any_req;
  logic [4:0] win_vec;
  logic step;
  logic soft_pending_q;

  isv_src_flags #(.N(N)) u_flags (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .evt(src_evt),
    .clr(src_clr),
    .enable(src_enable),
    .flag_q(src_flag),
    .request(request)
  );

  // lowest set index wins
  function automatic logic [4:0] pick(input logic [N-1:0] r);
    logic [4:0] v;
    v = 5'h1f;
    for (int i = N - 1; i >= 0; i--) begin
      if (r[i]) begin
        v = 5'(i);
      end
    end
    return v;
  endfunction : pick

  // slot address: vector 0 at the top, 31 at the bottom
  function automatic logic [15:0] vec_addr(input logic [4:0] v);
    return isv_pkg::VEC_TABLE_TOP - {10'h000, v, 1'b0};
  endfunction : vec_addr

  assign mask = condition_code_reg_q[isv_pkg::MASK_BIT];
  assign any_req = |request;
  assign win_vec = pick(request);
  assign step = mem_req & mem_ack;
  assign busy = (state_q != isv_pkg::ISV_RUN);
  assign mem_req = busy;
  assign mem_we = (state_q == isv_pkg::ISV_PUSH);
  assign resume = (state_q == isv_pkg::ISV_VEC_LO || state_q ==
    isv_pkg::ISV_FILL) && step && (state_q == isv_pkg::ISV_VEC_LO ||
    cnt_q == 3'(isv_pkg::PIPE_FILL_BYTES - 1));

  // state sequencing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= isv_pkg::ISV_RST_VEC;
      cnt_q <= '0;
      vec_q <= isv_pkg::VEC_RESET;
    end else begin
      case (state_q)
        isv_pkg::ISV_RUN: begin
          cnt_q <= '0;
          if (rst_cause) begin
            state_q <= isv_pkg::ISV_RST_VEC;
            vec_q <= isv_pkg::VEC_RESET;
          end else if (return_from_interrupt) begin
            state_q <= isv_pkg::ISV_POP;
          end else if (software_interrupt ||
                       (insn_boundary && any_req && !mask)) begin
            state_q <= isv_pkg::ISV_PUSH;
          end
        end
        isv_pkg::ISV_PUSH: begin
          if (step) begin
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q == 3'(isv_pkg::FRAME_BYTES - 1)) begin
              state_q <= isv_pkg::ISV_VEC_HI;
              // pending set sampled after stacking
              vec_q <= soft_pending_q ? isv_pkg::VEC_SOFT_INT :
                win_vec;
            end
          end
        end
        isv_pkg::ISV_RST_VEC, isv_pkg::ISV_VEC_HI: begin
          cnt_q <= '0;
          if (step) begin
            state_q <= isv_pkg::ISV_VEC_LO;
          end
        end
        isv_pkg::ISV_VEC_LO: begin
          if (step) begin
            state_q <= isv_pkg::ISV_RUN;
          end
        end
        isv_pkg::ISV_POP: begin
          if (step) begin
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q == 3'(isv_pkg::FRAME_BYTES - 1)) begin
              state_q <= isv_pkg::ISV_FILL;
              cnt_q <= '0;
            end
          end
        end
        isv_pkg::ISV_FILL: begin
          if (step) begin
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q == 3'(isv_pkg::PIPE_FILL_BYTES - 1)) begin
              state_q <= isv_pkg::ISV_RUN;
            end
          end
        end
        default: begin
          state_q <= isv_pkg::ISV_RUN;
        end
      endcase
    end
  end

  // entry caused by the software instruction rather than a source
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      soft_pending_q <= 1'b0;
    end else if (state_q == isv_pkg::ISV_RUN) begin
      soft_pending_q <= software_interrupt;
    end
  end

  // frame capture: low pc, high pc, x, a, flags; index high is left alone
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < isv_pkg::FRAME_BYTES; i++) begin
        frame_q[i] <= 8'h00;
      end
    end else if (state_q == isv_pkg::ISV_RUN) begin
      frame_q[0] <= next_pc[7:0];
      frame_q[1] <= next_pc[15:8];
      frame_q[2] <= idx_low_in;
      frame_q[3] <= acc_in;
      frame_q[4] <= condition_code_reg_q;
    end
  end

  // stack pointer: loaded in run, down on each push, up on each pop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stack_pointer_q <= isv_pkg::STACK_RESET;
    end else if (state_q == isv_pkg::ISV_RUN && stack_pointer_load) begin
      stack_pointer_q <= stack_pointer_in;
    end else if (state_q == isv_pkg::ISV_PUSH && step) begin
      stack_pointer_q <= stack_pointer_q - 8'h01;
    end else if (state_q == isv_pkg::ISV_POP && step) begin
      stack_pointer_q <= stack_pointer_q + 8'h01;
    end
  end

  // address presented for the current step
  always_comb begin
    mem_addr_q = isv_pkg::STACK_PAGE;
    mem_wdata_q = frame_q[cnt_q < 3'd5 ? cnt_q : 3'd0];
    case (state_q)
      isv_pkg::ISV_PUSH: mem_addr_q = {8'h00, stack_pointer_q};
      isv_pkg::ISV_POP: mem_addr_q = {8'h00, stack_pointer_q + 8'h01};
      isv_pkg::ISV_RST_VEC,
      isv_pkg::ISV_VEC_HI: mem_addr_q = vec_addr(vec_q);
      isv_pkg::ISV_VEC_LO: mem_addr_q = vec_addr(vec_q) + 16'h0001;
      isv_pkg::ISV_FILL: mem_addr_q = prog_counter_q + {13'h0000, cnt_q};
      default: mem_addr_q = isv_pkg::STACK_PAGE;
    endcase
  end

  // condition codes: mask set by reset and by entry, restored by return
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      condition_code_reg_q <= isv_pkg::COND_CODE_RESET;
    end else if (state_q == isv_pkg::ISV_RUN && condition_code_load) begin
      condition_code_reg_q <= condition_code_in;
    end else if ((state_q == isv_pkg::ISV_PUSH && step &&
                  cnt_q == 3'(isv_pkg::FRAME_BYTES - 1)) ||
                 state_q == isv_pkg::ISV_RST_VEC) begin
      condition_code_reg_q[isv_pkg::MASK_BIT] <= 1'b1;
    end else if (state_q == isv_pkg::ISV_POP && step && cnt_q == 3'd0) begin
      condition_code_reg_q <= mem_rdata;
    end
  end

  // restored registers and vector fetch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prog_counter_q <= 16'h0000;
      acc_q <= 8'h00;
      idx_low_q <= 8'h00;
      fill_byte_q <= 8'h00;
      fill_valid_q <= 1'b0;
    end else begin
      fill_valid_q <= (state_q == isv_pkg::ISV_FILL) && step;
      if (step) begin
        fill_byte_q <= mem_rdata;
      end
      if (state_q == isv_pkg::ISV_POP && step) begin
        case (cnt_q)
          3'd1: acc_q <= mem_rdata;
          3'd2: idx_low_q <= mem_rdata;
          3'd3: prog_counter_q[15:8] <= mem_rdata;
          3'd4: prog_counter_q[7:0] <= mem_rdata;
          default: acc_q <= acc_q;
        endcase
      end else if (step && (state_q == isv_pkg::ISV_VEC_HI ||
                            state_q == isv_pkg::ISV_RST_VEC)) begin
        prog_counter_q[15:8] <= mem_rdata;
      end else if (step && state_q == isv_pkg::ISV_VEC_LO) begin
        prog_counter_q[7:0] <= mem_rdata;
      end
    end
  end
endmodule : isv_core

// File: verification/isv_mem_model.sv
`timescale 1ns/1ps
module isv_mem_model (
  // clock and pace
  input wire logic sys_clk,
  input wire logic slow,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr_q,
  input wire logic [7:0] mem_wdata_q,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic odd_q;
  initial begin
    odd_q = 1'b0;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    // vector v points at 0xa000 + v, high byte at the lower address
    for (int v = 0; v < 32; v++) begin
      mem[16'hfffe - 16'(2 * v)] = 8'ha0;
      mem[16'hffff - 16'(2 * v)] = 8'(v);
    end
  end
  always @(posedge sys_clk) begin
    odd_q <= ~odd_q;
    if (mem_req && mem_we && mem_ack) begin
      mem[mem_addr_q] <= mem_wdata_q;
    end
  end
  // a slow memory takes only every other cycle
  assign mem_ack = mem_req & (~slow | odd_q);
  // outside an accepted read the data wobbles so it cannot be trusted
  assign mem_rdata = mem_ack ? mem[mem_addr_q] : {8{odd_q}} ^ 8'h3c;
endmodule : isv_mem_model

// File: verification/isv_core_chk.sv
`timescale 1ns/1ps
module isv_core_chk #(
  parameter int unsigned N = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic [N-1:0] src_evt,
  input wire logic [N-1:0] src_enable,
  input wire logic [N-1:0] src_flag,
  input wire logic rst_cause,
  input wire logic insn_boundary,
  input wire logic software_interrupt,
  input wire logic return_from_interrupt,
  input wire logic [15:0] next_pc,
  input wire logic busy,
  input wire logic mem_we,
  input wire logic mem_ack,
  input wire logic [15:0] mem_addr_q,
  input wire logic [7:0] mem_wdata_q,
  input wire logic [7:0] stack_pointer_q,
  input wire logic [7:0] condition_code_reg_q
);
  logic quiet;
  logic [7:0] pc_low;
  assign quiet = !busy && !software_interrupt && !return_from_interrupt &&
    !rst_cause;
  assign pc_low = next_pc[7:0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_push_step;
    mem_we && mem_ack ##1 mem_we;
  endsequence
  sequence s_push_done;
    $fell(mem_we) && busy;
  endsequence
  chk_mask_reset: assert property (
    !$past(rst_n) |-> condition_code_reg_q[3])
    else $error("mask clear after reset");
  chk_flag_sets: assert property (
    1'b1 |=> (src_flag & $past(src_evt)) == $past(src_evt))
    else $error("event did not set flag");
  chk_no_take: assert property (
    quiet && $past(rst_n, 2) && (condition_code_reg_q[3] ||
    (src_flag & src_enable) == '0 || !insn_boundary) |=> !busy)
    else $error("request taken while blocked");
  chk_push_first: assert property (
    $rose(busy) && mem_we |-> mem_addr_q == {8'h00, $past(stack_pointer_q)}
    && mem_wdata_q == $past(pc_low))
    else $error("first push wrong");
  chk_push_step: assert property (
    s_push_step |-> mem_addr_q == $past(mem_addr_q) - 16'h0001)
    else $error("push not downward");
  chk_sp_after: assert property (
    s_push_done |->
    {8'h00, stack_pointer_q} == $past(mem_addr_q) - 16'h0001)
    else $error("stack pointer after stacking wrong");
  chk_mask_vec: assert property (
    s_push_done |-> condition_code_reg_q[3] &&
    !mem_addr_q[0] && mem_addr_q >= 16'hffc0)
    else $error("vector fetch without mask");
  chk_vec_pair: assert property (
    busy && !mem_we && mem_ack && !mem_addr_q[0] && mem_addr_q >= 16'hffc0
    |=> busy && mem_addr_q == $past(mem_addr_q) + 16'h0001)
    else $error("vector low byte not next");
endmodule : isv_core_chk
bind isv_core isv_core_chk #(.N(N)) isv_core_chk_inst (.sys_clk, .rst_n,
  .src_evt, .src_enable, .src_flag, .rst_cause, .insn_boundary,
  .software_interrupt, .return_from_interrupt, .next_pc, .busy, .mem_we,
  .mem_ack, .mem_addr_q, .mem_wdata_q, .stack_pointer_q,
  .condition_code_reg_q);

// File: verification/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    error_cnt++; \
    $display("FAIL %0t mismatch", $time); \
  end \
end
module tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, insn_boundary = 1'b0;
  logic software_interrupt = 1'b0, return_from_interrupt = 1'b0;
  logic rst_cause = 1'b0, condition_code_load = 1'b0;
  logic stack_pointer_load = 1'b0, slow = 1'b0;
  logic [31:0] src_evt = '0, src_clr = '0, src_enable = '0, src_flag;
  logic [15:0] next_pc = '0, fill_pc = '0, mem_addr_q, prog_counter_q;
  logic [7:0] acc_in = '0, idx_low_in = '0;
  logic [7:0] condition_code_in = '0, stack_pointer_in = '0;
  logic mem_req, mem_we, mem_ack, busy, resume, fill_valid_q;
  logic [7:0] mem_wdata_q, mem_rdata, acc_q, idx_low_q, fill_byte_q;
  logic [7:0] condition_code_reg_q, stack_pointer_q;
  int error_cnt = 0, comparisons = 0, fills = 0;
  isv_core isv_core_inst (.sys_clk, .rst_n, .src_evt, .src_clr, .src_enable,
    .rst_cause, .insn_boundary, .software_interrupt, .return_from_interrupt,
    .next_pc, .acc_in, .idx_low_in, .condition_code_in, .condition_code_load,
    .stack_pointer_in, .stack_pointer_load, .mem_req, .mem_we,
    .mem_addr_q, .mem_wdata_q, .mem_ack, .mem_rdata, .busy, .resume,
    .prog_counter_q, .acc_q, .idx_low_q, .condition_code_reg_q,
    .stack_pointer_q, .fill_byte_q, .fill_valid_q, .src_flag);
  isv_mem_model isv_mem_model_inst (.sys_clk, .slow, .mem_req, .mem_we,
    .mem_addr_q, .mem_wdata_q, .mem_ack, .mem_rdata);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] mem_at(input logic [15:0] a);
    return isv_mem_model_inst.mem[a];
  endfunction : mem_at
  task automatic tick();
    @(negedge sys_clk);
  endtask : tick
  task automatic wait_idle();
    int n;
    int seen;
    n = 0;
    seen = 0;
    do begin
      tick();
      if (resume === 1'b1) begin
        seen++;
      end
      if (fill_valid_q === 1'b1) begin
        `CHK(fill_byte_q, 8'(fill_pc + 16'(fills)) ^ 8'h5a)
        fills++;
      end
      n++;
    end while (busy !== 1'b0 && n < 100);
    `CHK(busy, 1'b0)
    `CHK(seen, 1)
  endtask : wait_idle
  task automatic t_reset();
    repeat (2) tick();
    `CHK({condition_code_reg_q, stack_pointer_q}, 16'h08ff)
    rst_n = 1'b1;
    wait_idle();
    `CHK(prog_counter_q, 16'ha000)
    rst_cause = 1'b1;
    tick();
    rst_cause = 1'b0;
    `CHK(busy, 1'b1)
    wait_idle();
    `CHK(prog_counter_q, 16'ha000)
  endtask : t_reset
  task automatic t_gate();
    stack_pointer_in = 8'h80;
    stack_pointer_load = 1'b1;
    condition_code_load = 1'b1;
    insn_boundary = 1'b1;
    src_evt = 32'h0000_0028;
    tick();
    {stack_pointer_load, condition_code_load, src_evt} = '0;
    repeat (3) tick();
    `CHK(busy, 1'b0)
    `CHK(src_flag, 32'h0000_0028)
    insn_boundary = 1'b0;
  endtask : t_gate
  task automatic t_entry();
    slow = 1'b1;
    next_pc = 16'h1234;
    acc_in = 8'ha5;
    idx_low_in = 8'h3c;
    src_enable = 32'h0000_0028;
    insn_boundary = 1'b1;
    tick();
    insn_boundary = 1'b0;
    wait_idle();
    `CHK({mem_at(16'h0080), mem_at(16'h007f), mem_at(16'h007e),
      mem_at(16'h007d), mem_at(16'h007c)}, 40'h34_123c_a500)
    `CHK(stack_pointer_q, 8'h7b)
    `CHK(prog_counter_q, 16'ha003)
    insn_boundary = 1'b1;
    repeat (3) tick();
    `CHK(busy, 1'b0)
    insn_boundary = 1'b0;
  endtask : t_entry
  task automatic t_return();
    slow = 1'b0;
    src_clr = 32'h0000_0008;
    next_pc = 16'h2000;
    tick();
    src_clr = '0;
    fill_pc = 16'h1234;
    fills = 0;
    return_from_interrupt = 1'b1;
    tick();
    return_from_interrupt = 1'b0;
    wait_idle();
    `CHK(fills, 3)
    `CHK({acc_q, idx_low_q, condition_code_reg_q, stack_pointer_q},
      32'ha53c_0080)
    `CHK(prog_counter_q, 16'h1234)
  endtask : t_return
  task automatic t_next_soft();
    insn_boundary = 1'b1;
    tick();
    insn_boundary = 1'b0;
    wait_idle();
    `CHK(prog_counter_q, 16'ha005)
    software_interrupt = 1'b1;
    tick();
    software_interrupt = 1'b0;
    wait_idle();
    `CHK({prog_counter_q, stack_pointer_q, mem_at(16'h007b)}, 32'ha001_7600)
  endtask : t_next_soft
  task automatic test_done();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #50000;
    error_cnt++;
    test_done();
  end
  initial begin
    t_reset();
    t_gate();
    t_entry();
    t_return();
    t_next_soft();
    test_done();
  end
endmodule : tb
